/* File: lrc_defines.svh */
`ifndef LRC_DEFINES_SVH
`define LRC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets on the serial control register port
// ----------------------------------------------------------------------
`define LRC_ADDR_ENABLE      8'h0b
`define LRC_ADDR_PAIR_CFG    8'h0c
`define LRC_ADDR_THREE_CFG   8'h0d
`define LRC_ADDR_FOUR_CFG    8'h0e
`define LRC_ADDR_FIVE_CFG    8'h0f

// ----------------------------------------------------------------------
// Power-up values
// ----------------------------------------------------------------------
// Regulators one to five on, card supply off at 1.80 V, backup on.
`define LRC_RST_ENABLE       8'hfd
// Both discharge enables set, codes 100 (2.85 V) and 111 (3.3 V).
`define LRC_RST_PAIR_CFG     8'hcf
// Discharge set, code 1 (1.25 V).
`define LRC_RST_THREE_CFG    8'h81
// Discharge set, code 60 (2.75 V).
`define LRC_RST_FOUR_CFG     8'hbc
// Discharge set, code 62 (2.81 V).
`define LRC_RST_FIVE_CFG     8'hbe
// Value returned for an address this block does not hold.
`define LRC_RD_UNMAPPED      8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LRC_EN_ONE_BIT       7
`define LRC_EN_FIVE_BIT      3
`define LRC_EN_CARD_SEL_BIT  2
`define LRC_EN_CARD_ON_BIT   1
`define LRC_EN_BACKUP_BIT    0
`define LRC_PAIR_ONE_DIS_BIT 7
`define LRC_PAIR_ONE_CODE_HI 6
`define LRC_PAIR_ONE_CODE_LO 4
`define LRC_PAIR_TWO_DIS_BIT 3
`define LRC_PAIR_TWO_CODE_HI 2
`define LRC_PAIR_TWO_CODE_LO 0
`define LRC_CFG_DIS_BIT      7
`define LRC_CFG_CODE_HI      6

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define LRC_NUM_PROG         5
`define LRC_NUM_PG           9

`endif

/* File: lrc_pkg.sv */
`default_nettype none

`include "lrc_defines.svh"

package lrc_pkg;

    // Register-port request from the serial interface front end.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lrc_req_t;

    // Whole state of the regulator control block.
    typedef struct packed {
        logic [7:0]                 enable;
        logic [7:0]                 pair_cfg;
        logic [7:0]                 three_cfg;
        logic [7:0]                 four_cfg;
        logic [7:0]                 five_cfg;
        logic [7:0]                 rdata;
        logic [1:0]                 ac_sync;
        logic [1:0]                 usb_sync;
        logic [`LRC_NUM_PG-1:0]     pg_sync1;
        logic [`LRC_NUM_PG-1:0]     pg_sync2;
        logic [`LRC_NUM_PG-1:0]     pg_good;
        logic [`LRC_NUM_PG-1:0]     pg_irq;
        logic [`LRC_NUM_PG-1:0]     pg_seq;
        logic [`LRC_NUM_PROG-1:0]   on;
        logic [`LRC_NUM_PROG-1:0]   discharge;
        logic                       pm_on;
    } lrc_state_t;

endpackage

`default_nettype wire

/* File: lrc_regulator_ctrl.sv */
// Function
// - Every regulator except the input-power one has a host-written on bit.
// - Card-supply select bit chooses 3.0 V when clear, 1.80 V when set.
// - Input-power regulator is on whenever wall or USB input is detected.
// - Regulators one to five discharge their output when switched off.
// - Cleared discharge-enable bit leaves a switched-off output undischarged.
// - Discharge-enable bits come up set after power-up.
// - Power-good reads false while the comparator reports below 90 percent.
// - Power-good failures go to interrupts or sequencing by a setting.
// - Pair register: bit 7 and 6:4 for one, bit 3 and 2:0 for two.
// - Three and four: bit 7 discharge, 6:0 code; default 1.25 and 2.75 V.
// - Seven-bit code 0 gives 1.224 V, code 127 gives 4.463 V.

`default_nettype none

`include "lrc_defines.svh"

module lrc_regulator_ctrl (
    input  wire logic                      clk_i,            // Core clock.
    input  wire logic                      rstn_i,           // Reset, low.
    input  wire lrc_pkg::lrc_req_t         req_i,            // Reg access.
    output logic [7:0]                     rdata_o,          // Read data.
    input  wire logic                      ac_detect_i,      // Wall input.
    input  wire logic                      usb_detect_i,     // USB input.
    input  wire logic [`LRC_NUM_PG-1:0]    pg_below_i,       // Below 90 %.
    input  wire logic                      pg_to_seq_i,      // Route select.
    output logic [`LRC_NUM_PROG-1:0]       reg_on_o,         // One..five on.
    output logic [`LRC_NUM_PROG-1:0]       discharge_o,      // Discharge sw.
    output logic                           card_supply_on_o, // Card on.
    output logic                           card_supply_voltage_select_o, // Sel.
    output logic                           backup_on_o,      // Backup on.
    output logic                           pm_on_o,          // Input-pwr reg.
    output logic [2:0]                     reg_one_code_o,   // One code.
    output logic [2:0]                     reg_two_code_o,   // Two code.
    output logic [6:0]                     reg_three_code_o, // Three code.
    output logic [6:0]                     reg_four_code_o,  // Four code.
    output logic [6:0]                     reg_five_code_o,  // Five code.
    output logic [`LRC_NUM_PG-1:0]         power_good_o,     // Good flags.
    output logic [`LRC_NUM_PG-1:0]         pg_irq_o,         // To interrupts.
    output logic [`LRC_NUM_PG-1:0]         pg_seq_o          // To sequencer.
);
    import lrc_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    lrc_state_t st_r;
    lrc_state_t st_nxt;

    // Per-regulator discharge enables gathered from the config fields.
    logic [`LRC_NUM_PROG-1:0] dis_en;
    // On bits of regulators one to five, regulator one in bit 0.
    logic [`LRC_NUM_PROG-1:0] on_bits;

    // Discharge enables gathered into one vector, regulator one first.
    always_comb begin
        dis_en[0] = st_r.pair_cfg[`LRC_PAIR_ONE_DIS_BIT];
        dis_en[1] = st_r.pair_cfg[`LRC_PAIR_TWO_DIS_BIT];
        dis_en[2] = st_r.three_cfg[`LRC_CFG_DIS_BIT];
        dis_en[3] = st_r.four_cfg[`LRC_CFG_DIS_BIT];
        dis_en[4] = st_r.five_cfg[`LRC_CFG_DIS_BIT];
        for (int i = 0; i < `LRC_NUM_PROG; i++) begin
            on_bits[i] = st_r.enable[`LRC_EN_ONE_BIT - i];
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Register writes, read mux, synchronisers and switch drive.
    always_comb begin
        st_nxt = st_r;

        // Host writes land in whole bytes; every bit is writable.
        if (req_i.wr) begin
            unique case (req_i.addr)
                `LRC_ADDR_ENABLE:    st_nxt.enable    = req_i.wdata;
                `LRC_ADDR_PAIR_CFG:  st_nxt.pair_cfg  = req_i.wdata;
                `LRC_ADDR_THREE_CFG: st_nxt.three_cfg = req_i.wdata;
                `LRC_ADDR_FOUR_CFG:  st_nxt.four_cfg  = req_i.wdata;
                `LRC_ADDR_FIVE_CFG:  st_nxt.five_cfg  = req_i.wdata;
                default: ;
            endcase
        end

        // Reads return the stored byte; unknown addresses read zero.
        if (req_i.rd) begin
            unique case (req_i.addr)
                `LRC_ADDR_ENABLE:    st_nxt.rdata = st_r.enable;
                `LRC_ADDR_PAIR_CFG:  st_nxt.rdata = st_r.pair_cfg;
                `LRC_ADDR_THREE_CFG: st_nxt.rdata = st_r.three_cfg;
                `LRC_ADDR_FOUR_CFG:  st_nxt.rdata = st_r.four_cfg;
                `LRC_ADDR_FIVE_CFG:  st_nxt.rdata = st_r.five_cfg;
                default:             st_nxt.rdata = `LRC_RD_UNMAPPED;
            endcase
        end

        // Input detection passes two flip-flops before use.
        st_nxt.ac_sync  = {st_r.ac_sync[0], ac_detect_i};
        st_nxt.usb_sync = {st_r.usb_sync[0], usb_detect_i};
        // The input-power regulator follows either detected input.
        st_nxt.pm_on = st_r.ac_sync[1] | st_r.usb_sync[1];

        // Regulator switches: on bit drives the regulator, and a switched
        // off regulator closes its discharge switch only when enabled.
        st_nxt.on        = on_bits;
        st_nxt.discharge = ~on_bits & dis_en;

        // Comparator results are asynchronous, so they are synchronised.
        st_nxt.pg_sync1 = pg_below_i;
        st_nxt.pg_sync2 = st_r.pg_sync1;
        st_nxt.pg_good  = ~st_r.pg_sync2;
        // A failing regulator is reported to exactly one consumer.
        st_nxt.pg_irq = ~st_r.pg_good & {`LRC_NUM_PG{~pg_to_seq_i}};
        st_nxt.pg_seq = ~st_r.pg_good & {`LRC_NUM_PG{pg_to_seq_i}};
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Power-up values turn discharge on and set the default voltages.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r           <= '0;
            st_r.enable    <= `LRC_RST_ENABLE;
            st_r.pair_cfg  <= `LRC_RST_PAIR_CFG;
            st_r.three_cfg <= `LRC_RST_THREE_CFG;
            st_r.four_cfg  <= `LRC_RST_FOUR_CFG;
            st_r.five_cfg  <= `LRC_RST_FIVE_CFG;
            st_r.on        <= 5'h1f;
            st_r.pg_good   <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output is a field of the state register.
    assign rdata_o                      = st_r.rdata;
    assign reg_on_o                     = st_r.on;
    assign discharge_o                  = st_r.discharge;
    assign card_supply_on_o             = st_r.enable[`LRC_EN_CARD_ON_BIT];
    // Clear selects 3.0 V, set selects 1.80 V at the card regulator.
    assign card_supply_voltage_select_o =
        st_r.enable[`LRC_EN_CARD_SEL_BIT];
    assign backup_on_o                  = st_r.enable[`LRC_EN_BACKUP_BIT];
    assign pm_on_o                      = st_r.pm_on;
    // Codes go to the analog side unchanged; the seven-bit codes step
    // from 1.224 V at zero to 4.463 V at full scale.
    assign reg_one_code_o   =
        st_r.pair_cfg[`LRC_PAIR_ONE_CODE_HI:`LRC_PAIR_ONE_CODE_LO];
    assign reg_two_code_o   =
        st_r.pair_cfg[`LRC_PAIR_TWO_CODE_HI:`LRC_PAIR_TWO_CODE_LO];
    assign reg_three_code_o = st_r.three_cfg[`LRC_CFG_CODE_HI:0];
    assign reg_four_code_o  = st_r.four_cfg[`LRC_CFG_CODE_HI:0];
    assign reg_five_code_o  = st_r.five_cfg[`LRC_CFG_CODE_HI:0];
    assign power_good_o     = st_r.pg_good;
    assign pg_irq_o         = st_r.pg_irq;
    assign pg_seq_o         = st_r.pg_seq;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // A write to the enable register shows on the switches two edges on.
    enable_write_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_ENABLE
        |-> ##2 reg_on_o == {$past(req_i.wdata[3], 2),
                             $past(req_i.wdata[4], 2),
                             $past(req_i.wdata[5], 2),
                             $past(req_i.wdata[6], 2),
                             $past(req_i.wdata[7], 2)}
            && card_supply_on_o == $past(req_i.wdata[1], 2))
        else $error("enable write not applied to switches");

    // Card voltage select follows the written bit one edge later.
    card_select_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_ENABLE
        |=> card_supply_voltage_select_o == $past(req_i.wdata[2]))
        else $error("card voltage select not taken");

    // Either detected input turns the input-power regulator on.
    pm_follow_a: assert property (
        (ac_detect_i || usb_detect_i) |-> ##3 pm_on_o)
        else $error("input-power regulator not switched on");

    // With both inputs absent the input-power regulator goes off.
    pm_off_a: assert property (
        (!ac_detect_i && !usb_detect_i) |-> ##3 !pm_on_o)
        else $error("input-power regulator not switched off");

    // Discharge closes only for an enabled, switched-off regulator.
    discharge_sw_a: assert property (
        discharge_o == ($past(~on_bits) & $past(dis_en)))
        else $error("discharge switch mismatch");

    // A regulator with discharge disabled never discharges.
    discharge_off_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_THREE_CFG && !req_i.wdata[7]
        ##1 !(req_i.wr && req_i.addr == `LRC_ADDR_THREE_CFG)
        |=> !discharge_o[2])
        else $error("discharge active while disabled");

    // Read-back of a control register returns the stored byte.
    read_back_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_PAIR_CFG
        ##1 !(req_i.wr && req_i.addr == `LRC_ADDR_PAIR_CFG)
        ##1 req_i.rd && req_i.addr == `LRC_ADDR_PAIR_CFG && !req_i.wr
        |=> rdata_o == $past(req_i.wdata, 3))
        else $error("read-back differs from written value");

    // Unmapped reads answer zero.
    read_unmapped_a: assert property (
        req_i.rd && (req_i.addr < `LRC_ADDR_ENABLE
                     || req_i.addr > `LRC_ADDR_FIVE_CFG)
        |=> rdata_o == `LRC_RD_UNMAPPED)
        else $error("unmapped read not zero");

    // A comparator low report clears power-good three edges later.
    pg_fail_a: assert property (
        pg_below_i[0] |-> ##3 !power_good_o[0])
        else $error("power-good not cleared on low output");

    // A failure goes to the consumer chosen by the route select.
    pg_route_a: assert property (
        !power_good_o[0] |=> (pg_irq_o[0] == !$past(pg_to_seq_i))
                          && (pg_seq_o[0] == $past(pg_to_seq_i)))
        else $error("power-good failure misrouted");

    // No failure is sent to both consumers at once.
    pg_exclusive_a: assert property (
        (pg_irq_o & pg_seq_o) == '0)
        else $error("power-good failure sent twice");

    // Power-up leaves every discharge enable set.
    reset_discharge_a: assert property (
        !$past(rstn_i) |-> dis_en == 5'h1f)
        else $error("discharge enables not set after reset");

    // Power-up codes of regulators three and four.
    reset_codes_a: assert property (
        !$past(rstn_i)
        |-> {dis_en[2], reg_three_code_o} == `LRC_RST_THREE_CFG
            && {dis_en[3], reg_four_code_o} == `LRC_RST_FOUR_CFG)
        else $error("power-up codes of three and four wrong");

    // Power-up codes of the paired regulators.
    reset_pair_a: assert property (
        !$past(rstn_i)
        |-> {dis_en[0], reg_one_code_o, dis_en[1], reg_two_code_o}
            == `LRC_RST_PAIR_CFG)
        else $error("power-up codes of the pair wrong");

    // Paired codes follow their written fields one edge later.
    pair_write_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_PAIR_CFG
        |=> reg_one_code_o == $past(req_i.wdata[6:4])
            && reg_two_code_o == $past(req_i.wdata[2:0]))
        else $error("pair codes not taken");

    // A seven-bit code reaches the regulator unchanged.
    three_write_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_THREE_CFG
        |=> reg_three_code_o == $past(req_i.wdata[6:0]))
        else $error("regulator three code not taken");

    // Regulator four takes discharge enable and code together.
    four_write_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_FOUR_CFG
        |=> reg_four_code_o == $past(req_i.wdata[6:0])
            && dis_en[3] == $past(req_i.wdata[7]))
        else $error("regulator four config not taken");

    // Card and backup switches follow bits 1 and 0.
    card_backup_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_ENABLE
        |=> card_supply_on_o == $past(req_i.wdata[1])
            && backup_on_o == $past(req_i.wdata[0]))
        else $error("card or backup switch not taken");

    // Switching regulator one off with discharge enabled closes it.
    discharge_on_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_ENABLE && !req_i.wdata[7]
        && dis_en[0] |-> ##2 discharge_o[0])
        else $error("discharge switch not closed on turn-off");

    // Regulator three with discharge disabled stays undischarged.
    discharge_keep_a: assert property (
        req_i.wr && req_i.addr == `LRC_ADDR_ENABLE && !req_i.wdata[5]
        && !dis_en[2] |-> ##2 !discharge_o[2])
        else $error("disabled discharge switch closed");

    // A regulator that is on never has its discharge switch closed.
    on_discharge_a: assert property (
        (reg_on_o & discharge_o) == '0)
        else $error("discharge switch closed on a live regulator");

    // Read data holds between reads.
    rdata_hold_a: assert property (
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without a read");

    // Power-good returns three edges after the comparator clears.
    pg_recover_a: assert property (
        !pg_below_i[0] |-> ##3 power_good_o[0])
        else $error("power-good not restored");

endmodule

`default_nettype wire

/* File: lrc_host_model.sv */
`default_nettype none

// Host side of the register port: one byte request at a time.
module lrc_host_model (
    input  wire logic            clk_i,   // Core clock.
    output var lrc_pkg::lrc_req_t req_o,  // Register request.
    input  wire logic [7:0]      rdata_i  // Read data.
);
    timeunit 1ns;
    timeprecision 1ps;
    import lrc_pkg::*;

    // The port is idle from time zero.
    initial req_o = '0;

    // Drive just after an edge, hold through the taking edge, then release.
    // Released address and data are inverted so stale values never match.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        #1;
        req_o = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        q = rdata_i;
        req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
`default_nettype none

`include "lrc_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lrc_pkg::*;

    // Row of the table: address, byte written, byte read back.
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
    } lrc_row_t;

    logic            clk_i = 1'b0;
    logic            rstn_i = 1'b0;
    lrc_req_t        req;
    logic [7:0]      rdata, q;
    logic            ac = 1'b0, usb = 1'b0, to_seq = 1'b0;
    logic [8:0]      below = '0, pg, irq, seq;
    logic [4:0]      on, dis;
    logic            c_on, c_sel, bk, pm;
    logic [2:0]      c1, c2;
    logic [6:0]      c3, c4, c5;
    int              n_mismatch = 0;
    int              n_compared = 0;
    lrc_row_t        rows [7] = '{
        '{8'h0b, 8'h5a, 8'h5a}, '{8'h0c, 8'ha5, 8'ha5},
        '{8'h0d, 8'h7f, 8'h7f}, '{8'h0e, 8'hff, 8'hff},
        '{8'h0f, 8'h00, 8'h00}, '{8'h10, 8'h33, 8'h00},
        '{8'h0a, 8'hff, 8'h00}};

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    lrc_host_model i_lrc_host_model (.clk_i(clk_i), .req_o(req),
        .rdata_i(rdata));

    lrc_regulator_ctrl i_lrc_regulator_ctrl (.clk_i(clk_i),
        .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata),
        .ac_detect_i(ac), .usb_detect_i(usb), .pg_below_i(below),
        .pg_to_seq_i(to_seq), .reg_on_o(on), .discharge_o(dis),
        .card_supply_on_o(c_on), .card_supply_voltage_select_o(c_sel),
        .backup_on_o(bk), .pm_on_o(pm), .reg_one_code_o(c1),
        .reg_two_code_o(c2), .reg_three_code_o(c3),
        .reg_four_code_o(c4), .reg_five_code_o(c5),
        .power_good_o(pg), .pg_irq_o(irq), .pg_seq_o(seq));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compares a value read back over the register port.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    // Compares a level driven on the output pins.
    task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t out got %h exp %h", $time, got, exp);
        end
    endtask

    // Write and read helpers, and a wait past the output latency.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_lrc_host_model.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_lrc_host_model.xfer(1'b0, a, 8'h00, q);
        chk_reg(q, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Stops a hung run well after the tests should have finished.
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end

    // Main sequence: reset, table rows, then the awkward cases.
    initial begin
        settle(4);
        rstn_i = 1'b1;
        chk_out({4'h0, on}, 9'h01f);
        chk_out({4'h0, dis}, 9'h000);
        chk_out({6'h0, c_on, c_sel, bk}, 9'h003);
        chk_out({c1, c2, 3'h0}, {3'b100, 3'b111, 3'h0});
        chk_out({2'h0, c3}, 9'h001);
        chk_out({2'h0, c4}, 9'h03c);
        chk_out({2'h0, c5}, 9'h03e);
        rd(`LRC_ADDR_PAIR_CFG, 8'hcf);
        rd(`LRC_ADDR_FOUR_CFG, 8'hbc);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q);
        end
        $display("test table done");
        wr(`LRC_ADDR_PAIR_CFG, 8'h88);
        wr(`LRC_ADDR_THREE_CFG, 8'h00);
        wr(`LRC_ADDR_FOUR_CFG, 8'h80);
        wr(`LRC_ADDR_FIVE_CFG, 8'h80);
        wr(`LRC_ADDR_ENABLE, 8'h00);
        settle(3);
        chk_out({4'h0, on}, 9'h000);
        chk_out({4'h0, dis}, 9'h01b);
        chk_out({c1, c2, 3'h0}, 9'h000);
        chk_out({c3, 2'h0}, 9'h000);
        chk_out({2'h0, c5}, 9'h000);
        wr(`LRC_ADDR_ENABLE, 8'h50);
        settle(3);
        chk_out({4'h0, on}, 9'h00a);
        chk_out({4'h0, dis}, 9'h011);
        chk_out({6'h0, c_on, c_sel, bk}, 9'h000);
        wr(`LRC_ADDR_ENABLE, 8'h06);
        settle(3);
        chk_out({6'h0, c_on, c_sel, bk}, 9'h006);
        $display("test discharge done");
        ac = 1'b1;
        settle(5);
        chk_out({8'h0, pm}, 9'h001);
        ac = 1'b0;
        usb = 1'b1;
        settle(5);
        chk_out({8'h0, pm}, 9'h001);
        usb = 1'b0;
        settle(5);
        chk_out({8'h0, pm}, 9'h000);
        $display("test input power done");
        below = 9'h101;
        settle(5);
        chk_out(pg, 9'h0fe);
        chk_out(irq, 9'h101);
        chk_out(seq, 9'h000);
        to_seq = 1'b1;
        settle(5);
        chk_out(irq, 9'h000);
        chk_out(seq, 9'h101);
        below = 9'h000;
        settle(5);
        chk_out(pg, 9'h1ff);
        $display("test power good done");
        // A reset in mid-run brings back the power-up values.
        rstn_i = 1'b0;
        settle(2);
        rstn_i = 1'b1;
        chk_out({4'h0, on}, 9'h01f);
        chk_out({4'h0, dis}, 9'h000);
        chk_out({6'h0, c_on, c_sel, bk}, 9'h003);
        chk_out({2'h0, c5}, 9'h03e);
        rd(`LRC_ADDR_THREE_CFG, 8'h81);
        rd(`LRC_ADDR_ENABLE, 8'hfd);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule

`default_nettype wire
